// *** pkg/pin_input_pkg.sv ***
// Constants and types shared by the pin input path and its checker
// Function
// - Per-pin interrupt mode none, rising, falling or both; reset value none.
// - All unmasked pin interrupt requests of the port OR into one port interrupt.
// - Each pin level passes a bus-clock synchroniser by default.
// - Per-pin bypass delivers the raw pin level; synchronised is default.
// - Disabled input buffer hides the pin level from routing and reads.
// - Buffer enable resets off for analog-only pins, on for all others.
// - Special pin hysteresis forced off on logic thresholds; default off.
// - Enabled hardware connection drives the pin level onto internal routing.
// - Processor can read the level of every buffer-enabled pin through a register.
package pin_input_pkg;

   // ==========================================================
   // Register bus
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // ==========================================================
   // Register byte addresses
   localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_BUF_EN = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SYNC_BYPASS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_HW_CONN = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MODE = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_SPECIAL_IO = 8'h1C;

   // ==========================================================
   // Field layout of the special pin register
   localparam int THRESH_LSB = 0;
   localparam int THRESH_W = 3;
   localparam int HYST_BIT = 4;

   // ==========================================================
   // Encodings
   localparam int MODE_W = 2;
   localparam logic [MODE_W-1:0] MODE_NONE = 2'h0;
   localparam logic [MODE_W-1:0] MODE_RISE = 2'h1;
   localparam logic [MODE_W-1:0] MODE_FALL = 2'h2;
   localparam logic [MODE_W-1:0] MODE_BOTH = 2'h3;

   // Threshold codes; codes below THRESH_FIRST_SUPPLY are logic families
   localparam logic [THRESH_W-1:0] THRESH_CMOS = 3'h0;
   localparam logic [THRESH_W-1:0] THRESH_LVTTL = 3'h1;
   localparam logic [THRESH_W-1:0] THRESH_CMOS_LVTTL = 3'h2;
   localparam logic [THRESH_W-1:0] THRESH_FIRST_SUPPLY = 3'h3;

   // ==========================================================
   // Reset values
   localparam logic [THRESH_W-1:0] RST_THRESH = THRESH_CMOS;
   localparam logic RST_HYST = 1'b0;
   localparam logic RST_BYPASS = 1'b0;
   localparam logic RST_HW_CONN = 1'b1;
   localparam logic RST_MASK = 1'b1;

   // ==========================================================
   // Synchroniser depth
   localparam int SYNC_STAGES = 2;

endpackage : pin_input_pkg

// *** rtl/pin_sync.sv ***
// Two-flop synchroniser bringing pin levels into the bus clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_state_t;

   sync_state_t s_r;
   sync_state_t s_nxt;

   // First stage feeds only the second stage
   always_comb begin
      s_nxt = s_r;
      s_nxt.meta = async_in;
      s_nxt.stable = s_r.meta;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sync_out = s_r.stable;

endmodule : pin_sync
`default_nettype wire

// *** rtl/pin_input_port.sv ***
// Digital input path of one pin port with edge interrupts and registers
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pin_input_port #(
   parameter int NUM_PINS = 8,
   // Pins configured purely as analog; their buffers reset disabled
   parameter logic [NUM_PINS-1:0] ANALOG_ONLY = '0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [pin_input_pkg::ADDR_W-1:0] addr,
   input wire logic [pin_input_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [pin_input_pkg::DATA_W-1:0] rdata,
   input wire logic [NUM_PINS-1:0] pin_in,
   output logic [NUM_PINS-1:0] routed_in,
   output logic port_irq,
   output logic [pin_input_pkg::THRESH_W-1:0] special_io_pin_thresh,
   output logic special_io_pin_hyst_en
);

   localparam int MODE_BITS = NUM_PINS * pin_input_pkg::MODE_W;

   // ==========================================================
   // State
   typedef struct packed {
      logic [NUM_PINS-1:0] buf_en;
      logic [NUM_PINS-1:0] bypass;
      logic [NUM_PINS-1:0] hw_conn;
      logic [MODE_BITS-1:0] mode;
      logic [NUM_PINS-1:0] status;
      logic [NUM_PINS-1:0] mask;
      logic [pin_input_pkg::THRESH_W-1:0] thresh;
      logic hyst;
      logic [NUM_PINS-1:0] level;
      logic [NUM_PINS-1:0] prev;
      logic [NUM_PINS-1:0] routed;
      logic irq;
      logic [pin_input_pkg::DATA_W-1:0] rdata;
   } port_state_t;

   localparam port_state_t RST_STATE = '{
      buf_en: ~ANALOG_ONLY,
      bypass: {NUM_PINS{pin_input_pkg::RST_BYPASS}},
      hw_conn: {NUM_PINS{pin_input_pkg::RST_HW_CONN}},
      mode: {NUM_PINS{pin_input_pkg::MODE_NONE}},
      status: '0,
      mask: {NUM_PINS{pin_input_pkg::RST_MASK}},
      thresh: pin_input_pkg::RST_THRESH,
      hyst: pin_input_pkg::RST_HYST,
      level: '0,
      prev: '0,
      routed: '0,
      irq: 1'b0,
      rdata: '0
   };

   port_state_t s_r;
   port_state_t s_nxt;

   pin_input_pkg::reg_req_t req;
   logic [NUM_PINS-1:0] sync_lvl;
   logic [NUM_PINS-1:0] edge_hit;
   logic [NUM_PINS-1:0] edge_lvl;
   logic status_read;

   // ==========================================================
   // Helpers

   // Edge of the selected polarity for one pin
   function automatic logic edge_match(
      input logic [pin_input_pkg::MODE_W-1:0] mode,
      input logic cur,
      input logic old
   );
      logic hit;
      hit = 1'b0;
      case (mode)
         pin_input_pkg::MODE_RISE: begin
            hit = cur & ~old;
         end
         pin_input_pkg::MODE_FALL: begin
            hit = ~cur & old;
         end
         pin_input_pkg::MODE_BOTH: begin
            hit = cur ^ old;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      return hit;
   endfunction : edge_match

   // Pin-wide field placed in the low bits of a data word
   function automatic logic [pin_input_pkg::DATA_W-1:0] pin_word(
      input logic [NUM_PINS-1:0] v
   );
      logic [pin_input_pkg::DATA_W-1:0] w;
      w = '0;
      w[NUM_PINS-1:0] = v;
      return w;
   endfunction : pin_word

   // Logic-family thresholds cannot use the differential hysteresis
   function automatic logic hyst_allowed(
      input logic [pin_input_pkg::THRESH_W-1:0] th
   );
      return th >= pin_input_pkg::THRESH_FIRST_SUPPLY;
   endfunction : hyst_allowed

   // ==========================================================
   // Synchroniser
   pin_sync #(
      .W(NUM_PINS)
   ) u_sync (
      .clk(clk),
      .rstn(rstn),
      .async_in(pin_in),
      .sync_out(sync_lvl)
   );

   // ==========================================================
   // Bus request bundle
   always_comb begin
      req.addr = addr;
      req.wdata = wdata;
      req.wr = wr;
      req.rd = rd;
   end

   assign status_read = req.rd && (req.addr == pin_input_pkg::OFS_IRQ_STATUS);

   // ==========================================================
   // Edge detection on the synchronised, buffer-gated sample
   always_comb begin
      edge_lvl = sync_lvl & s_r.buf_en;
      for (int i = 0; i < NUM_PINS; i++) begin
         edge_hit[i] = edge_match(
            s_r.mode[i*pin_input_pkg::MODE_W +: pin_input_pkg::MODE_W],
            edge_lvl[i], s_r.prev[i]);
      end
   end

   // ==========================================================
   // Next state
   always_comb begin
      s_nxt = s_r;

      // Bypassed pins take the raw level straight into this flop; that
      // trades metastability safety for two fewer cycles of latency
      for (int i = 0; i < NUM_PINS; i++) begin
         if (s_r.bypass[i]) begin
            s_nxt.level[i] = pin_in[i] & s_r.buf_en[i];
         end else begin
            s_nxt.level[i] = sync_lvl[i] & s_r.buf_en[i];
         end
      end
      s_nxt.routed = s_nxt.level & s_r.hw_conn;
      s_nxt.prev = edge_lvl;

      // Register writes
      if (req.wr) begin
         if (req.addr == pin_input_pkg::OFS_BUF_EN) begin
            s_nxt.buf_en = req.wdata[NUM_PINS-1:0];
         end else if (req.addr == pin_input_pkg::OFS_SYNC_BYPASS) begin
            s_nxt.bypass = req.wdata[NUM_PINS-1:0];
         end else if (req.addr == pin_input_pkg::OFS_HW_CONN) begin
            s_nxt.hw_conn = req.wdata[NUM_PINS-1:0];
         end else if (req.addr == pin_input_pkg::OFS_IRQ_MODE) begin
            s_nxt.mode = req.wdata[MODE_BITS-1:0];
         end else if (req.addr == pin_input_pkg::OFS_IRQ_MASK) begin
            s_nxt.mask = req.wdata[NUM_PINS-1:0];
         end else if (req.addr == pin_input_pkg::OFS_SPECIAL_IO) begin
            s_nxt.thresh = req.wdata[pin_input_pkg::THRESH_LSB +:
                                     pin_input_pkg::THRESH_W];
            s_nxt.hyst = req.wdata[pin_input_pkg::HYST_BIT] &
               hyst_allowed(req.wdata[pin_input_pkg::THRESH_LSB +:
                                      pin_input_pkg::THRESH_W]);
         end
      end

      // Sticky flags: a read clears, but a new edge in that cycle wins
      if (status_read) begin
         s_nxt.status = edge_hit;
      end else begin
         s_nxt.status = s_r.status | edge_hit;
      end

      // One level interrupt for the whole port
      s_nxt.irq = |(s_nxt.status & s_nxt.mask);

      // Read data stands for one cycle only
      s_nxt.rdata = '0;
      if (req.rd) begin
         if (req.addr == pin_input_pkg::OFS_PIN_LEVEL) begin
            s_nxt.rdata = pin_word(s_r.level);
         end else if (req.addr == pin_input_pkg::OFS_BUF_EN) begin
            s_nxt.rdata = pin_word(s_r.buf_en);
         end else if (req.addr == pin_input_pkg::OFS_SYNC_BYPASS) begin
            s_nxt.rdata = pin_word(s_r.bypass);
         end else if (req.addr == pin_input_pkg::OFS_HW_CONN) begin
            s_nxt.rdata = pin_word(s_r.hw_conn);
         end else if (req.addr == pin_input_pkg::OFS_IRQ_MODE) begin
            s_nxt.rdata[MODE_BITS-1:0] = s_r.mode;
         end else if (req.addr == pin_input_pkg::OFS_IRQ_STATUS) begin
            s_nxt.rdata = pin_word(s_r.status);
         end else if (req.addr == pin_input_pkg::OFS_IRQ_MASK) begin
            s_nxt.rdata = pin_word(s_r.mask);
         end else if (req.addr == pin_input_pkg::OFS_SPECIAL_IO) begin
            s_nxt.rdata[pin_input_pkg::THRESH_LSB +:
                        pin_input_pkg::THRESH_W] = s_r.thresh;
            s_nxt.rdata[pin_input_pkg::HYST_BIT] = s_r.hyst;
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= RST_STATE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign rdata = s_r.rdata;
   assign routed_in = s_r.routed;
   assign port_irq = s_r.irq;
   assign special_io_pin_thresh = s_r.thresh;
   assign special_io_pin_hyst_en = s_r.hyst;

endmodule : pin_input_port
`default_nettype wire

// *** bench/pin_source.sv ***
// Off-chip signal sources driving the port pins
`timescale 1ns/1ps
`default_nettype none
module pin_source #(
   parameter int W = 8
) (
   input wire logic [W-1:0] level,
   output wire logic [W-1:0] pins
);
   // Skewed off the clock edge, like a real asynchronous source
   assign #7 pins = level;
endmodule : pin_source
`default_nettype wire

// *** bench/pin_input_port_properties.sv ***
// Checker for the pin input port outputs
`timescale 1ns/1ps
`default_nettype none
module pin_input_port_properties #(
   parameter int NUM_PINS = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [pin_input_pkg::ADDR_W-1:0] addr,
   input wire logic [pin_input_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [pin_input_pkg::DATA_W-1:0] rdata,
   input wire logic [NUM_PINS-1:0] pin_in,
   input wire logic [NUM_PINS-1:0] routed_in,
   input wire logic port_irq,
   input wire logic [pin_input_pkg::THRESH_W-1:0] special_io_pin_thresh,
   input wire logic special_io_pin_hyst_en
);
   // =====
   // Helper state
   logic wrote_r;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrote_r <= 1'b0;
      end else if (wr) begin
         wrote_r <= 1'b1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Six calm cycles flush the sync, level and edge stages
   sequence quiet_s;
      (!wr && !rd && $stable(pin_in)) [*6];
   endsequence
   sequence level_rd_s;
      $stable(pin_in) [*5] ##0
         (rd && !wrote_r && addr == pin_input_pkg::OFS_PIN_LEVEL);
   endsequence
   // =====
   // Assertions
   rdata_idle_a: assert property (
      !$past(rd) |-> rdata == '0) else $error("rdata not idle");
   hyst_forced_a: assert property (
      special_io_pin_thresh < pin_input_pkg::THRESH_FIRST_SUPPLY
      |-> !special_io_pin_hyst_en) else $error("hysteresis not forced off");
   spio_write_a: assert property (
      wr && addr == pin_input_pkg::OFS_SPECIAL_IO
      |=> special_io_pin_thresh ==
         $past(wdata[pin_input_pkg::THRESH_LSB +: pin_input_pkg::THRESH_W])
      && special_io_pin_hyst_en == ($past(wdata[pin_input_pkg::HYST_BIT])
         && $past(wdata[pin_input_pkg::THRESH_LSB +: pin_input_pkg::THRESH_W])
            >= pin_input_pkg::THRESH_FIRST_SUPPLY))
      else $error("special pin write wrong");
   routed_quiet_a: assert property (
      quiet_s |=> $stable(routed_in)) else $error("routed moved unprovoked");
   irq_quiet_a: assert property (
      quiet_s |=> $stable(port_irq)) else $error("irq moved unprovoked");
   irq_fall_a: assert property (
      $fell(port_irq)
      |-> $past(rd) || $past(wr) || $past(rd, 2) || $past(wr, 2))
      else $error("irq dropped without access");
   irq_default_a: assert property (
      !wrote_r |-> !port_irq) else $error("irq before any setup");
   level_read_a: assert property (
      level_rd_s |=> rdata == 32'(routed_in) && routed_in == pin_in)
      else $error("pin level read wrong");
endmodule : pin_input_port_properties
bind pin_input_port pin_input_port_properties #(.NUM_PINS(NUM_PINS)) u_props (
   .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .pin_in(pin_in), .routed_in(routed_in),
   .port_irq(port_irq), .special_io_pin_thresh(special_io_pin_thresh),
   .special_io_pin_hyst_en(special_io_pin_hyst_en));
`default_nettype wire

// *** bench/pin_input_path_edge_irq_test.sv ***
// Register-level testbench of the pin input port
`timescale 1ns/1ps
`default_nettype none
module pin_input_path_edge_irq_test;
   logic clk, rstn, wr, rd, port_irq, hyst;
   logic [7:0] addr, level, pin_in, routed_in;
   logic [31:0] wdata, rdata;
   logic [2:0] thresh;
   int fails, tests_run, p;
   pin_source src (.level(level), .pins(pin_in));
   // Pin 6 is analog-only; it stays low through the reset checks
   pin_input_port #(.NUM_PINS(8), .ANALOG_ONLY(8'h40)) DUT (
      .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
      .routed_in(routed_in), .port_irq(port_irq),
      .special_io_pin_thresh(thresh), .special_io_pin_hyst_en(hyst));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // =====
   // Tasks
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic set_pins(input logic [7:0] v);
      @(posedge clk);
      level <= v;
   endtask : set_pins
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic chk(input string what, input logic [31:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), exp, rdata);
   endtask : rchk
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
   // =====
   // Tests
   initial begin
      rstn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = '0;
      wdata = '0;
      level = 8'ha5;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rchk(8'h10, '0);
      rchk(8'h04, 32'h0000_00bf);
      rchk(8'h08, '0);
      rchk(8'h0c, 32'h0000_00ff);
      rchk(8'h18, 32'h0000_00ff);
      rchk(8'h1c, '0);
      rchk(8'h00, 32'h0000_00a5);
      chk("routed", 32'h0000_00a5, routed_in);
      rchk(8'h40, '0);
      wr_reg(8'h04, 32'h0000_00ff);
      rchk(8'h04, 32'h0000_00ff);
      $display("test reset values done");
      set_pins(8'h3c);
      tick(2);
      chk("routed", 32'h0000_00a5, routed_in);
      tick(1);
      chk("routed", 32'h0000_003c, routed_in);
      wr_reg(8'h08, 32'h0000_00ff);
      set_pins(8'hc3);
      tick(1);
      chk("routed", 32'h0000_00c3, routed_in);
      wr_reg(8'h08, '0);
      $display("test synchroniser done");
      wr_reg(8'h0c, '0);
      tick(1);
      chk("routed", '0, routed_in);
      rchk(8'h00, 32'h0000_00c3);
      wr_reg(8'h0c, 32'h0000_00ff);
      wr_reg(8'h04, 32'h0000_000f);
      tick(2);
      rchk(8'h00, 32'h0000_0003);
      chk("routed", 32'h0000_0003, routed_in);
      wr_reg(8'h04, 32'h0000_00ff);
      $display("test gating done");
      for (int m = 1; m < 4; m++) begin
         p = 2 * m - 1;
         set_pins('0);
         tick(5);
         wr_reg(8'h10, 32'(m << (2 * p)));
         set_pins(8'(1 << p));
         tick(5);
         chk("irq", 32'(m & 1), port_irq);
         rchk(8'h14, 32'((m & 1) << p));
         tick(1);
         chk("irq", '0, port_irq);
         set_pins('0);
         tick(5);
         rchk(8'h14, 32'((m >> 1) << p));
      end
      wr_reg(8'h18, '0);
      set_pins(8'h20);
      tick(5);
      chk("irq", '0, port_irq);
      wr_reg(8'h18, 32'h0000_00ff);
      tick(1);
      chk("irq", 32'h0000_0001, port_irq);
      rchk(8'h14, 32'h0000_0020);
      tick(1);
      chk("irq", '0, port_irq);
      $display("test edge interrupts done");
      wr_reg(8'h1c, 32'h0000_0011);
      rchk(8'h1c, 32'h0000_0001);
      chk("hyst", '0, hyst);
      wr_reg(8'h1c, 32'h0000_0013);
      rchk(8'h1c, 32'h0000_0013);
      chk("hyst", 32'h0000_0001, hyst);
      chk("thresh", 32'h0000_0003, thresh);
      $display("test special pin done");
      print_verdict();
   end
endmodule : pin_input_path_edge_irq_test
`default_nettype wire
